// >>> hw/fifo_port_regs.svh
`ifndef FIFO_PORT_REGS_SVH
`define FIFO_PORT_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_RXDATA 8'h08
`define OFS_TXDATA 8'h0C
`define OFS_EVENT 8'h10

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define CTRL_W 14
`define CTRL_SEL_A_LSB 0
`define CTRL_SEL_B_LSB 4
`define CTRL_WAKE_EN_BIT 8
`define CTRL_SUSPEND_BIT 9
`define CTRL_CONFIG_BIT 10
`define CTRL_CHARGER_BIT 11
`define CTRL_GPIO_WR_BIT 12
`define CTRL_GPIO_RD_BIT 13
`define CTRL_RESET 14'h3100

// ----------------------------------------------------------------------
// Status, data and event fields
// ----------------------------------------------------------------------
`define STAT_RX_FULL_BIT 0
`define STAT_TX_FULL_BIT 1
`define STAT_WAKE_BIT 2
`define STAT_VBUS_BIT 3
`define STAT_INHIBIT_BIT 4
`define STAT_PIN_A_BIT 5
`define STAT_PIN_B_BIT 6
`define TXDATA_VALID_BIT 8
`define EVT_SOF_BIT 0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SYS_CLK_HZ 10000000
`define WAKE_MIN_MS 20
`define WAKE_CYCLES (`WAKE_MIN_MS * (`SYS_CLK_HZ / 1000))
`define WAKE_CNT_W 18
`define DIV_W 3

`endif

// >>> hw/fifo_port_pkg.sv
package fifo_port_pkg;

   // ----------------------------------------------------------------------
   // Option pin functions
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      OPT_TRISTATE = 4'h0,
      OPT_DRIVE_HIGH = 4'h1,
      OPT_DRIVE_LOW = 4'h2,
      OPT_POWER_EN = 4'h3,
      OPT_SLEEP_N = 4'h4,
      OPT_CLK_FAST = 4'h5,
      OPT_CLK_MID = 4'h6,
      OPT_CLK_SLOW = 4'h7,
      OPT_CHARGER = 4'h8,
      OPT_CHARGER_N = 4'h9,
      OPT_GPIO_WR = 4'hA,
      OPT_GPIO_RD = 4'hB,
      OPT_VBUS_SENSE = 4'hC,
      OPT_TIME_STAMP = 4'hD,
      OPT_KEEP_AWAKE = 4'hE
   } opt_sel_e;

   // ----------------------------------------------------------------------
   // Wake detector states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      WK_IDLE = 2'b00,
      WK_COUNT = 2'b01,
      WK_DONE = 2'b11
   } wake_state_e;

   typedef logic [7:0] byte_t;

endpackage

// >>> hw/usb_state_if.sv
`timescale 1ns/1ns
`default_nettype none

interface usb_state_if;
   logic suspended;
   logic configured;
   logic charger;
   logic gpio_wr_n;
   logic gpio_rd_n;
   logic clk_fast;
   logic clk_mid;
   logic clk_slow;
   logic time_stamp;

   modport src (
      output suspended, configured, charger, gpio_wr_n, gpio_rd_n,
      output clk_fast, clk_mid, clk_slow, time_stamp
   );
   modport sink (
      input suspended, configured, charger, gpio_wr_n, gpio_rd_n,
      input clk_fast, clk_mid, clk_slow, time_stamp
   );
endinterface

`default_nettype wire

// >>> hw/option_pin.sv
`timescale 1ns/1ns
`default_nettype none

module option_pin
   import fifo_port_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Shared device state
   usb_state_if.sink st,
   // Selection and pin
   input wire opt_sel_e sel,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   // Sensed inputs
   output logic vbus_seen,
   output logic keep_awake_seen
);

   logic out_next;
   logic oe_next;
   logic out_reg;
   logic oe_reg;

   always_comb begin
      out_next = 1'b0;
      oe_next = 1'b1;
      unique case (sel)
         OPT_TRISTATE: oe_next = 1'b0;
         OPT_DRIVE_HIGH: out_next = 1'b1;
         OPT_DRIVE_LOW: out_next = 1'b0;
         OPT_POWER_EN: out_next = ~st.configured | st.suspended;
         OPT_SLEEP_N: out_next = ~st.suspended;
         OPT_CLK_FAST: out_next = st.clk_fast;
         OPT_CLK_MID: out_next = st.clk_mid;
         OPT_CLK_SLOW: out_next = st.clk_slow;
         OPT_CHARGER: out_next = st.charger;
         OPT_CHARGER_N: out_next = ~st.charger;
         OPT_GPIO_WR: out_next = st.gpio_wr_n;
         OPT_GPIO_RD: out_next = st.gpio_rd_n;
         OPT_VBUS_SENSE: oe_next = 1'b0;
         OPT_TIME_STAMP: out_next = st.time_stamp;
         OPT_KEEP_AWAKE: oe_next = 1'b0;
         default: oe_next = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else begin
         out_reg <= out_next;
         oe_reg <= oe_next;
      end
   end

   assign pin_out = out_reg;
   assign pin_oe = oe_reg;
   assign vbus_seen = (sel == OPT_VBUS_SENSE) & pin_in;
   assign keep_awake_seen = (sel == OPT_KEEP_AWAKE) & ~pin_in;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   property p_drive_high;
      @(posedge sys_clk) disable iff (!rst_n)
      (sel == OPT_DRIVE_HIGH) ##1 (sel == OPT_DRIVE_HIGH) |-> pin_out && pin_oe;
   endproperty
   a_drive_high: assert property (p_drive_high) else $error("drive high option not high");

   property p_sleep_ind;
      @(posedge sys_clk) disable iff (!rst_n)
      (sel == OPT_SLEEP_N) && st.suspended |=> !pin_out || $changed(st.suspended);
   endproperty
   a_sleep_ind: assert property (p_sleep_ind) else $error("sleep option high in suspend");

endmodule

`default_nettype wire

// >>> hw/fifo_port.sv
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "fifo_port_regs.svh"

module fifo_port
   import fifo_port_pkg::*;
#(
   parameter int WAKE_CYCLES = `WAKE_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Parallel FIFO port
   input wire logic [7:0] fifo_data_bus_in,
   output logic [7:0] fifo_data_bus_out,
   output logic [7:0] fifo_data_bus_oe,
   input wire logic read_strobe_n,
   input wire logic write_strobe,
   output logic room_available_n_out,
   output logic room_available_n_oe,
   input wire logic data_waiting_n_in,
   output logic data_waiting_n_out,
   output logic data_waiting_n_oe,
   // Option pins
   input wire logic option_pin_a_in,
   output logic option_pin_a_out,
   output logic option_pin_a_oe,
   input wire logic option_pin_b_in,
   output logic option_pin_b_out,
   output logic option_pin_b_oe,
   // System indications
   output logic resume_request,
   output logic vbus_present,
   output logic suspend_inhibit
);

   localparam logic [`WAKE_CNT_W-1:0] WAKE_LAST = `WAKE_CNT_W'(WAKE_CYCLES - 1);

   // ----------------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------------
   logic rst_s1_reg;
   logic rst_n;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n <= rst_s1_reg;
      end
   end

   // ----------------------------------------------------------------------
   // Strobe synchronisers
   // ----------------------------------------------------------------------
   // The data bus is delayed alongside the write strobe so that the byte
   // captured belongs to the same sample as the detected falling edge.
   logic rd_s1_reg, rd_s2_reg, rd_s3_reg;
   logic wr_s1_reg, wr_s2_reg, wr_s3_reg;
   byte_t data_s1_reg, data_s2_reg;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_s1_reg <= 1'b1;
         rd_s2_reg <= 1'b1;
         rd_s3_reg <= 1'b1;
         wr_s1_reg <= 1'b0;
         wr_s2_reg <= 1'b0;
         wr_s3_reg <= 1'b0;
         data_s1_reg <= 8'h00;
         data_s2_reg <= 8'h00;
      end else begin
         rd_s1_reg <= read_strobe_n;
         rd_s2_reg <= rd_s1_reg;
         rd_s3_reg <= rd_s2_reg;
         wr_s1_reg <= write_strobe;
         wr_s2_reg <= wr_s1_reg;
         wr_s3_reg <= wr_s2_reg;
         data_s1_reg <= fifo_data_bus_in;
         data_s2_reg <= data_s1_reg;
      end
   end

   wire rd_fall = rd_s3_reg & ~rd_s2_reg;
   wire wr_fall = wr_s3_reg & ~wr_s2_reg;

   // ----------------------------------------------------------------------
   // Avalon-MM decode
   // ----------------------------------------------------------------------
   // Every access takes one wait state; read data is registered in the
   // wait cycle so it stands steady at the edge where waitrequest is low.
   logic served_reg;
   logic [31:0] readdata_reg;
   logic [`CTRL_W-1:0] ctrl_reg;
   logic rx_full_reg, tx_full_reg, wake_flag_reg, time_stamp_reg;
   byte_t rx_byte_reg, tx_byte_reg;
   logic [`DIV_W-1:0] div_cnt_reg;
   logic pin_a_in_w, pin_b_in_w;

   wire req = avs_read | avs_write;
   wire accept = req & served_reg;
   wire rd_acc = accept & avs_read;
   wire wr_acc = accept & avs_write;
   wire hit_ctrl = (avs_address == `OFS_CTRL);
   wire hit_status = (avs_address == `OFS_STATUS);
   wire hit_rxdata = (avs_address == `OFS_RXDATA);
   wire hit_txdata = (avs_address == `OFS_TXDATA);
   wire hit_event = (avs_address == `OFS_EVENT);

   wire wake_en = ctrl_reg[`CTRL_WAKE_EN_BIT];
   wire suspended = ctrl_reg[`CTRL_SUSPEND_BIT];
   wire wake_mode = wake_en & suspended;

   wire [31:0] status_w = {25'h0000000, option_pin_b_in, option_pin_a_in, suspend_inhibit,
      vbus_present, wake_flag_reg, tx_full_reg, rx_full_reg};
   wire [31:0] txdata_w = {23'h000000, tx_full_reg, tx_byte_reg};
   wire [31:0] ctrl_w = {18'h00000, ctrl_reg};
   wire [31:0] rd_mux = hit_ctrl ? ctrl_w :
      hit_status ? status_w :
      hit_txdata ? txdata_w : 32'h00000000;

   wire tx_pop = rd_acc & hit_txdata & readdata_reg[`TXDATA_VALID_BIT];
   wire rx_load = wr_acc & hit_rxdata & ~rx_full_reg & rd_s2_reg;
   wire rx_take = rd_fall & rx_full_reg;
   wire tx_take = wr_fall & (~tx_full_reg | tx_pop);
   wire sof_evt = wr_acc & hit_event & avs_writedata[`EVT_SOF_BIT];
   wire wake_clr = wr_acc & hit_status & avs_writedata[`STAT_WAKE_BIT];

   assign avs_waitrequest = req & ~served_reg;
   assign avs_readdata = readdata_reg;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         served_reg <= 1'b0;
         readdata_reg <= 32'h00000000;
      end else begin
         served_reg <= req & ~served_reg;
         if (avs_read & ~served_reg) begin
            readdata_reg <= rd_mux;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= `CTRL_RESET;
      end else if (wr_acc & hit_ctrl) begin
         ctrl_reg <= avs_writedata[`CTRL_W-1:0];
      end
   end

   // ----------------------------------------------------------------------
   // Receive and transmit holding bytes
   // ----------------------------------------------------------------------
   // A receive load is ignored while a read strobe is low, so the byte
   // on the bus never changes in the middle of a host read.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_full_reg <= 1'b0;
         rx_byte_reg <= 8'h00;
      end else if (rx_load) begin
         rx_full_reg <= 1'b1;
         rx_byte_reg <= avs_writedata[7:0];
      end else if (rx_take) begin
         rx_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_full_reg <= 1'b0;
         tx_byte_reg <= 8'h00;
      end else if (tx_take) begin
         tx_full_reg <= 1'b1;
         tx_byte_reg <= data_s2_reg;
      end else if (tx_pop) begin
         tx_full_reg <= 1'b0;
      end
   end

   assign fifo_data_bus_out = rx_byte_reg;
   assign fifo_data_bus_oe = {8{rst_n & ~rd_s2_reg}};
   assign room_available_n_out = tx_full_reg;
   assign room_available_n_oe = rst_n;
   assign data_waiting_n_out = ~rx_full_reg;
   assign data_waiting_n_oe = rst_n & ~wake_mode;

   // ----------------------------------------------------------------------
   // Remote wake detector
   // ----------------------------------------------------------------------
   wake_state_e wake_state_reg, wake_state_next;
   logic [`WAKE_CNT_W-1:0] wake_cnt_reg, wake_cnt_next;
   logic wake_hit;

   wire wake_low = wake_mode & ~data_waiting_n_in;

   always_comb begin
      wake_state_next = wake_state_reg;
      wake_cnt_next = wake_cnt_reg;
      wake_hit = 1'b0;
      unique case (wake_state_reg)
         WK_IDLE: begin
            if (wake_low) begin
               wake_state_next = WK_COUNT;
               wake_cnt_next = `WAKE_CNT_W'(1);
            end
         end
         WK_COUNT: begin
            if (!wake_low) begin
               wake_state_next = WK_IDLE;
            end else if (wake_cnt_reg == WAKE_LAST) begin
               wake_state_next = WK_DONE;
               wake_hit = 1'b1;
            end else begin
               wake_cnt_next = wake_cnt_reg + `WAKE_CNT_W'(1);
            end
         end
         WK_DONE: begin
            if (!wake_low) begin
               wake_state_next = WK_IDLE;
            end
         end
         default: wake_state_next = WK_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_state_reg <= WK_IDLE;
         wake_cnt_reg <= '0;
         wake_flag_reg <= 1'b0;
      end else begin
         wake_state_reg <= wake_state_next;
         wake_cnt_reg <= wake_cnt_next;
         wake_flag_reg <= wake_hit | (wake_flag_reg & ~wake_clr);
      end
   end

   assign resume_request = wake_hit;

   // ----------------------------------------------------------------------
   // Clock outputs and time stamp
   // ----------------------------------------------------------------------
   // The output clocks are binary divisions of the system clock; they hold
   // their level while suspended instead of running.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_reg <= '0;
         time_stamp_reg <= 1'b0;
      end else begin
         if (!suspended) begin
            div_cnt_reg <= div_cnt_reg + `DIV_W'(1);
         end
         if (sof_evt) begin
            time_stamp_reg <= ~time_stamp_reg;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Option pins
   // ----------------------------------------------------------------------
   usb_state_if st ();

   assign st.suspended = suspended;
   assign st.configured = ctrl_reg[`CTRL_CONFIG_BIT];
   assign st.charger = ctrl_reg[`CTRL_CHARGER_BIT];
   assign st.gpio_wr_n = ctrl_reg[`CTRL_GPIO_WR_BIT];
   assign st.gpio_rd_n = ctrl_reg[`CTRL_GPIO_RD_BIT];
   assign st.clk_fast = div_cnt_reg[0];
   assign st.clk_mid = div_cnt_reg[1];
   assign st.clk_slow = div_cnt_reg[2];
   assign st.time_stamp = time_stamp_reg;

   logic [1:0] pin_in_w, pin_out_w, pin_oe_w, vbus_w, keep_w;
   assign pin_a_in_w = option_pin_a_in;
   assign pin_b_in_w = option_pin_b_in;
   assign pin_in_w = {pin_b_in_w, pin_a_in_w};

   for (genvar i = 0; i < 2; i++) begin : g_opt
      option_pin u_pin (
         .sys_clk(sys_clk),
         .rst_n(rst_n),
         .st(st),
         .sel(opt_sel_e'(ctrl_reg[4*i +: 4])),
         .pin_in(pin_in_w[i]),
         .pin_out(pin_out_w[i]),
         .pin_oe(pin_oe_w[i]),
         .vbus_seen(vbus_w[i]),
         .keep_awake_seen(keep_w[i])
      );
   end

   assign option_pin_a_out = pin_out_w[0];
   assign option_pin_a_oe = pin_oe_w[0];
   assign option_pin_b_out = pin_out_w[1];
   assign option_pin_b_oe = pin_oe_w[1];
   assign vbus_present = |vbus_w;
   assign suspend_inhibit = |keep_w;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   property p_bus_drive;
      @(posedge sys_clk) disable iff (!rst_n)
      !read_strobe_n [*3] |-> fifo_data_bus_oe == 8'hFF && fifo_data_bus_out == rx_byte_reg;
   endproperty
   a_bus_drive: assert property (p_bus_drive) else $error("bus not driven in read");

   property p_bus_float;
      @(posedge sys_clk) disable iff (!rst_n)
      read_strobe_n [*3] |-> fifo_data_bus_oe == 8'h00;
   endproperty
   a_bus_float: assert property (p_bus_float) else $error("bus driven outside read");

   property p_rx_advance;
      @(posedge sys_clk) disable iff (!rst_n)
      rd_fall && rx_full_reg |=> !rx_full_reg && data_waiting_n_out;
   endproperty
   a_rx_advance: assert property (p_rx_advance) else $error("read did not advance");

   property p_tx_capture;
      @(posedge sys_clk) disable iff (!rst_n)
      $fell(write_strobe) && !tx_full_reg && !served_reg ##1 !write_strobe
         |-> ##2 tx_full_reg && tx_byte_reg == $past(fifo_data_bus_in, 3);
   endproperty
   a_tx_capture: assert property (p_tx_capture) else $error("write byte not captured");

   property p_flags_reset;
      @(posedge sys_clk) disable iff (!nrst)
      !rst_n |-> !room_available_n_oe && !data_waiting_n_oe;
   endproperty
   a_flags_reset: assert property (p_flags_reset) else $error("flag driven in reset");

   property p_wake_count;
      @(posedge sys_clk) disable iff (!rst_n)
      wake_hit |-> wake_cnt_reg == WAKE_LAST && wake_low && data_waiting_n_oe == 1'b0;
   endproperty
   a_wake_count: assert property (p_wake_count) else $error("wake fired early");

   property p_single_edge;
      @(posedge sys_clk) disable iff (!rst_n)
      wr_fall |=> !wr_fall [*2];
   endproperty
   a_single_edge: assert property (p_single_edge) else $error("strobe acted twice");

   property p_time_stamp;
      @(posedge sys_clk) disable iff (!rst_n)
      sof_evt |=> time_stamp_reg != $past(time_stamp_reg);
   endproperty
   a_time_stamp: assert property (p_time_stamp) else $error("time stamp did not toggle");

   property p_clk_stop;
      @(posedge sys_clk) disable iff (!rst_n)
      suspended |=> $stable(div_cnt_reg);
   endproperty
   a_clk_stop: assert property (p_clk_stop) else $error("clock ran in suspend");

   property p_clk_run;
      @(posedge sys_clk) disable iff (!rst_n)
      rst_n && !suspended |=> div_cnt_reg == $past(div_cnt_reg) + `DIV_W'(1);
   endproperty
   a_clk_run: assert property (p_clk_run) else $error("clock divider stalled");

   property p_bus_answer;
      @(posedge sys_clk) disable iff (!rst_n)
      req && !served_reg |=> !avs_waitrequest || !req;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

   c_read: cover property (@(posedge sys_clk) disable iff (!rst_n) rx_take);
   c_write: cover property (@(posedge sys_clk) disable iff (!rst_n) tx_take);
   c_wake: cover property (@(posedge sys_clk) disable iff (!rst_n) wake_hit);
   c_sof: cover property (@(posedge sys_clk) disable iff (!rst_n) sof_evt);

endmodule

`default_nettype wire

// >>> bench/fifo_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module fifo_host_model (
   // Clock
   input wire logic sys_clk,
   // Device pins seen by the host
   input wire logic room_n,
   input wire logic data_n,
   input wire logic [7:0] bus_out,
   input wire logic [7:0] bus_oe,
   input wire logic dw_out,
   input wire logic dw_oe,
   // Host drive
   output logic [7:0] bus_in,
   output logic dw_in,
   output var logic rd_n = 1'b1,
   output var logic wr = 1'b1
);
   logic [7:0] drv = 8'h5A;
   logic wk_n = 1'b1;

   // A released bus shows the inverse of its last byte, so stale data never passes.
   assign bus_in = (bus_oe & bus_out) | (~bus_oe & drv);
   assign dw_in = dw_oe ? dw_out : wk_n;

   task automatic rd(output logic [7:0] b);
      b = 8'h00;
      @(posedge sys_clk);
      if (data_n === 1'b0) begin
         rd_n <= 1'b0;
         repeat (4) @(posedge sys_clk);
         b = bus_in;
         rd_n <= 1'b1;
      end
      repeat (4) @(posedge sys_clk);
   endtask

   task automatic wr_byte(input logic [7:0] b);
      @(posedge sys_clk);
      if (room_n === 1'b0) begin
         drv <= b;
         repeat (3) @(posedge sys_clk);
         wr <= 1'b0;
         repeat (4) @(posedge sys_clk);
         wr <= 1'b1;
         drv <= ~b;
      end
      repeat (3) @(posedge sys_clk);
   endtask
endmodule

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, rd_n, wr, dw_in, dw_out, dw_oe, room_n, room_oe, pa_out, pa_oe;
   logic pb_out, pb_oe, suspend_inhibit;
   logic [7:0] bus_in, bus_out, bus_oe, b;
   logic pa_in = 1'b1;
   logic pb_in = 1'b0;
   logic resume_request, vbus_present, t;
   int num_errors = 0;
   int n_checks = 0;
   int i;
   // Control word beside the expected {enable, driven level} of pin A.
   localparam logic [15:0] ROWS [14] = '{{14'h3100, 2'h0}, {14'h3101, 2'h3},
      {14'h3102, 2'h2}, {14'h3503, 2'h2}, {14'h3303, 2'h3}, {14'h3304, 2'h2},
      {14'h3104, 2'h3}, {14'h3908, 2'h3}, {14'h3909, 2'h2}, {14'h210A, 2'h2},
      {14'h110B, 2'h2}, {14'h310C, 2'h0}, {14'h310E, 2'h0}, {14'h310F, 2'h0}};

   always #50 sys_clk = ~sys_clk;

   fifo_port #(.WAKE_CYCLES(16)) dut (.sys_clk(sys_clk), .nrst(nrst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .fifo_data_bus_in(bus_in),
      .fifo_data_bus_out(bus_out), .fifo_data_bus_oe(bus_oe), .read_strobe_n(rd_n),
      .write_strobe(wr), .room_available_n_out(room_n), .room_available_n_oe(room_oe),
      .data_waiting_n_in(dw_in), .data_waiting_n_out(dw_out), .data_waiting_n_oe(dw_oe),
      .option_pin_a_in(pa_in), .option_pin_a_out(pa_out), .option_pin_a_oe(pa_oe),
      .option_pin_b_in(pb_in), .option_pin_b_out(pb_out), .option_pin_b_oe(pb_oe),
      .resume_request(resume_request), .vbus_present(vbus_present),
      .suspend_inhibit(suspend_inhibit));

   fifo_host_model mcu (.sys_clk(sys_clk), .room_n(room_n), .data_n(dw_out),
      .bus_out(bus_out), .bus_oe(bus_oe), .dw_out(dw_out), .dw_oe(dw_oe),
      .bus_in(bus_in), .dw_in(dw_in), .rd_n(rd_n), .wr(wr));

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   // The bus answer time is the slave's business, so only a bounded wait limits it.
   task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      if (avs_waitrequest !== 1'b0) begin
         num_errors++;
         end_of_test();
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   initial begin
      repeat (4) @(posedge sys_clk);
      chk({room_oe, dw_oe}, 2'h0);
      nrst <= 1'b1;
      repeat (5) @(posedge sys_clk);
      for (i = 0; i < 14; i++) begin
         av(1'b1, 8'h00, {18'h0, ROWS[i][15:2]});
         repeat (2) @(posedge sys_clk);
         chk({pa_oe, pa_out & pa_oe}, ROWS[i][1:0]);
      end
      $display("option table done");
      av(1'b1, 8'h00, 32'h31EC);
      repeat (2) @(posedge sys_clk);
      chk({vbus_present, suspend_inhibit, pb_oe}, 3'h6);
      pa_in <= 1'b0;
      pb_in <= 1'b1;
      @(posedge sys_clk);
      chk({vbus_present, suspend_inhibit}, 2'h0);
      av(1'b0, 8'h04, 32'h0);
      chk(q[6:0], 7'h40);
      av(1'b1, 8'h00, 32'h3112);
      repeat (2) @(posedge sys_clk);
      chk({pb_oe, pb_out, pa_oe, pa_out}, 4'hE);
      av(1'b1, 8'h00, 32'h310D);
      repeat (2) @(posedge sys_clk);
      t = pa_out;
      av(1'b1, 8'h10, 32'h1);
      repeat (2) @(posedge sys_clk);
      chk(pa_out ^ t, 1'b1);
      for (i = 0; i < 3; i++) begin
         av(1'b1, 8'h00, 32'h3105 + i);
         repeat (2) @(negedge sys_clk);
         t = pa_out;
         repeat (1 << i) @(negedge sys_clk);
         chk(pa_out ^ t, 1'b1);
      end
      av(1'b1, 8'h00, 32'h3305);
      repeat (2) @(negedge sys_clk);
      t = pa_out;
      repeat (3) @(negedge sys_clk);
      chk(pa_out, t);
      $display("option pins done");
      av(1'b1, 8'h00, 32'h3100);
      av(1'b1, 8'h08, 32'hA5);
      repeat (2) @(posedge sys_clk);
      chk(dw_out, 1'b0);
      mcu.rd(b);
      chk(b, 8'hA5);
      chk(dw_out, 1'b1);
      chk(bus_oe, 8'h00);
      mcu.wr_byte(8'h3C);
      chk(room_n, 1'b1);
      av(1'b0, 8'h0C, 32'h0);
      chk(q[8:0], 9'h13C);
      repeat (2) @(posedge sys_clk);
      chk(room_n, 1'b0);
      $display("fifo transfers done");
      av(1'b1, 8'h00, 32'h3300);
      repeat (2) @(posedge sys_clk);
      chk(dw_oe, 1'b0);
      mcu.wk_n <= 1'b0;
      for (i = 0; i < 40 && resume_request !== 1'b1; i++) @(negedge sys_clk);
      chk(i >= 16 && i < 24, 1'b1);
      av(1'b0, 8'h04, 32'h0);
      chk(q[2], 1'b1);
      av(1'b1, 8'h04, 32'h4);
      av(1'b0, 8'h04, 32'h0);
      chk(q[2], 1'b0);
      $display("wake done");
      mcu.wk_n <= 1'b1;
      nrst <= 1'b0;
      @(posedge sys_clk);
      chk({room_oe, dw_oe}, 2'h0);
      nrst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk({room_oe, dw_oe, room_n, dw_out}, 4'hD);
      $display("reset done");
      end_of_test();
   end
endmodule

`default_nettype wire
